// ==== include/fms_pkg.sv ====
// Constants and types shared by the flow meter serial slave.
package fms_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD_PER_UNIT = 10;
   localparam logic [15:0] RATE_480 = 16'h01e0;
   localparam logic [15:0] RATE_960 = 16'h03c0;
   localparam logic [15:0] RATE_1920 = 16'h0780;
   localparam logic [15:0] RATE_11520 = 16'h2d00;
   localparam logic [15:0] RATE_RST = RATE_960;
   // Bit periods in clock cycles, rounded down from the line rate.
   localparam int BIT_CYC_480 = CLK_HZ / (480 * BAUD_PER_UNIT);
   localparam int BIT_CYC_960 = CLK_HZ / (960 * BAUD_PER_UNIT);
   localparam int BIT_CYC_1920 = CLK_HZ / (1920 * BAUD_PER_UNIT);
   localparam int BIT_CYC_11520 = CLK_HZ / (11520 * BAUD_PER_UNIT);
   localparam logic [15:0] REG_FLOW = 16'h0000;
   localparam logic [15:0] REG_TEMP = 16'h0001;
   localparam logic [15:0] REG_RO_LAST = 16'h0004;
   localparam logic [15:0] REG_STATION = 16'h0028;
   localparam logic [15:0] REG_RATE = 16'h0029;
   localparam logic [7:0] STATION_RST = 8'h01;
   localparam logic [7:0] STATION_MIN = 8'h01;
   localparam logic [7:0] STATION_MAX = 8'h20;
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_WRITE = 8'h06;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [15:0] MAX_READ_REGS = 16'h007d;
   localparam logic [3:0] REQ_LEN = 4'h8;
   localparam logic [3:0] STOP_BIT = 4'h9;
   localparam logic [5:0] SILENCE_BITS = 6'h23;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [7:0] LEN_WRITE = 8'h08;
   localparam logic [7:0] LEN_EXC = 8'h05;
   localparam logic [7:0] LEN_READ_BASE = 8'h05;
   typedef enum logic [0:0] {LK_LISTEN = 1'b0, LK_SEND = 1'b1} fms_link_t;
endpackage : fms_pkg

// ==== logic/fms_crc_step.sv ====
// One byte step of the reflected 16-bit frame check.
`timescale 1ns/10ps
module fms_crc_step (
   input wire logic [15:0] crc_i,
   input wire logic [7:0] data_i,
   output logic [15:0] crc_o
);
   import fms_pkg::*;
   // Eight shift steps unrolled by the loop; the check is low byte first on the wire.
   always_comb begin
      logic [15:0] c;
      c = crc_i ^ {8'h00, data_i};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      crc_o = c;
   end
endmodule : fms_crc_step

// ==== logic/fms_modbus_slave.sv ====
// Serial bus slave answering register read and write requests.
`timescale 1ns/10ps
module fms_modbus_slave #(
   parameter int BIT_CYC_R480 = fms_pkg::BIT_CYC_480,
   parameter int BIT_CYC_R960 = fms_pkg::BIT_CYC_960,
   parameter int BIT_CYC_R1920 = fms_pkg::BIT_CYC_1920,
   parameter int BIT_CYC_R11520 = fms_pkg::BIT_CYC_11520
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic rx_i,
   input wire logic [15:0] flow_i,
   input wire logic [15:0] temp_i,
   output logic tx_o,
   output logic de_o,
   output logic [7:0] station_o,
   output logic [15:0] line_rate_o
);
   import fms_pkg::*;

   fms_link_t link_q;
   logic [7:0] station_q;
   logic [15:0] rate_q;
   logic [13:0] bit_cyc;
   logic rx_busy_q, rx_stb, rx_bad;
   logic [13:0] rx_cnt_q;
   logic [3:0] rx_bit_q;
   logic [7:0] rx_sh_q;
   logic [13:0] gap_cnt_q;
   logic [5:0] gap_bits_q;
   logic gap_tick, frame_end;
   logic [7:0] buf_q [0:7];
   logic [3:0] nbytes_q;
   logic bad_q;
   logic [15:0] crc_rx_q, crc_rx_n, crc_tx_q, crc_tx_n;
   logic accept;
   logic [15:0] a_w, v_w;
   logic [16:0] rd_end;
   logic [7:0] exc_d, exc_q;
   logic write_q, wr_station, wr_rate;
   logic [7:0] tx_len_q, tx_idx_q, tx_byte, off;
   logic [15:0] rd_word;
   logic tx_busy_q, tx_q, de_q;
   logic [13:0] tx_cnt_q;
   logic [3:0] tx_bit_q;
   logic [9:0] tx_sh_q;

   assign tx_o = tx_q;
   assign de_o = de_q;
   assign station_o = station_q;
   assign line_rate_o = rate_q;

   // Bit period follows the line-rate register; only legal codes can be stored.
   always_comb begin
      unique case (rate_q)
         RATE_480: bit_cyc = 14'(BIT_CYC_R480 - 1);
         RATE_1920: bit_cyc = 14'(BIT_CYC_R1920 - 1);
         RATE_11520: bit_cyc = 14'(BIT_CYC_R11520 - 1);
         default: bit_cyc = 14'(BIT_CYC_R960 - 1);
      endcase
   end

   // Receiver: start edge, half-bit wait, then one sample per bit mid-cell.
   assign rx_stb = rx_busy_q && (rx_cnt_q == 14'h0000) && (rx_bit_q == STOP_BIT);
   assign rx_bad = rx_stb && !rx_i;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_busy_q <= 1'b0;
         rx_cnt_q <= 14'h0000;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
      end else if (!rx_busy_q) begin
         if (!rx_i) begin
            rx_busy_q <= 1'b1;
            rx_cnt_q <= bit_cyc >> 1;
            rx_bit_q <= 4'h0;
         end
      end else if (rx_cnt_q != 14'h0000) begin
         rx_cnt_q <= rx_cnt_q - 14'h0001;
      end else begin
         rx_cnt_q <= bit_cyc;
         rx_bit_q <= rx_bit_q + 4'h1;
         if (rx_bit_q == 4'h0 && rx_i) begin
            rx_busy_q <= 1'b0; // A glitch, not a start bit.
         end else if (rx_bit_q == STOP_BIT) begin
            rx_busy_q <= 1'b0;
         end else if (rx_bit_q != 4'h0) begin
            rx_sh_q <= {rx_i, rx_sh_q[7:1]};
         end
      end
   end

   // Silence timer in bit periods; any line activity restarts it.
   assign gap_tick = (gap_cnt_q == bit_cyc);
   assign frame_end = gap_tick && (gap_bits_q == SILENCE_BITS - 6'h01) && (nbytes_q != 4'h0);
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gap_cnt_q <= 14'h0000;
         gap_bits_q <= 6'h00;
      end else if (rx_busy_q || !rx_i) begin
         gap_cnt_q <= 14'h0000;
         gap_bits_q <= 6'h00;
      end else if (gap_tick) begin
         gap_cnt_q <= 14'h0000;
         if (gap_bits_q != SILENCE_BITS) begin
            gap_bits_q <= gap_bits_q + 6'h01;
         end
      end else begin
         gap_cnt_q <= gap_cnt_q + 14'h0001;
      end
   end

   fms_crc_step u_crc_rx (
      .crc_i(crc_rx_q),
      .data_i(rx_sh_q),
      .crc_o(crc_rx_n)
   );

   // Frame collection; running the check over the whole frame leaves zero when intact.
   // Bytes heard while we drive the line are our own echo and are dropped.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         nbytes_q <= 4'h0;
         bad_q <= 1'b0;
         crc_rx_q <= CRC_INIT;
         for (int i = 0; i < 8; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (frame_end) begin
         nbytes_q <= 4'h0;
         bad_q <= 1'b0;
         crc_rx_q <= CRC_INIT;
      end else if (rx_stb && link_q == LK_LISTEN && !rx_bad) begin
         if (nbytes_q < REQ_LEN) begin
            buf_q[nbytes_q[2:0]] <= rx_sh_q;
         end
         if (nbytes_q <= REQ_LEN) begin
            nbytes_q <= nbytes_q + 4'h1; // Nine marks an overlong frame.
         end
         crc_rx_q <= crc_rx_n;
      end else if (rx_bad) begin
         bad_q <= 1'b1;
      end
   end

   // Only an intact eight-byte frame for our station gets an answer.
   assign accept = frame_end && link_q == LK_LISTEN && !bad_q && nbytes_q == REQ_LEN
                   && crc_rx_q == 16'h0000 && buf_q[0] == station_q;
   assign a_w = {buf_q[2], buf_q[3]};
   assign v_w = {buf_q[4], buf_q[5]};
   assign rd_end = {1'b0, a_w} + {1'b0, v_w} - 17'h00001;
   assign wr_station = (a_w == REG_STATION) && v_w >= {8'h00, STATION_MIN}
                       && v_w <= {8'h00, STATION_MAX};
   assign wr_rate = (a_w == REG_RATE) && (v_w == RATE_480 || v_w == RATE_960
                    || v_w == RATE_1920 || v_w == RATE_11520);

   // Exception code for the request, zero when it can be carried out.
   always_comb begin
      exc_d = 8'h00;
      if (buf_q[1] == FC_READ) begin
         if (v_w == 16'h0000 || v_w > MAX_READ_REGS) begin
            exc_d = EXC_VALUE;
         end else if (!(rd_end <= {1'b0, REG_RO_LAST} || (a_w >= REG_STATION
                      && rd_end <= {1'b0, REG_RATE}))) begin
            exc_d = EXC_ADDR;
         end
      end else if (buf_q[1] == FC_WRITE) begin
         if (a_w != REG_STATION && a_w != REG_RATE) begin
            exc_d = EXC_ADDR;
         end else if (!wr_station && !wr_rate) begin
            exc_d = EXC_VALUE;
         end
      end else begin
         exc_d = EXC_FUNC;
      end
   end

   // Configuration registers change only on an accepted write.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         station_q <= STATION_RST;
         rate_q <= RATE_RST;
      end else if (accept && buf_q[1] == FC_WRITE && exc_d == 8'h00) begin
         if (wr_station) begin
            station_q <= buf_q[5];
         end
         if (wr_rate) begin
            rate_q <= v_w;
         end
      end
   end

   // Register read map; reserved words read as zero.
   function automatic logic [15:0] reg_rd(input logic [15:0] a);
      if (a == REG_FLOW) return flow_i;
      if (a == REG_TEMP) return temp_i;
      if (a == REG_STATION) return {8'h00, station_q};
      if (a == REG_RATE) return rate_q;
      return 16'h0000;
   endfunction : reg_rd

   // Reply byte chosen by position; the check follows low byte first.
   assign off = tx_idx_q - 8'h03;
   // The addressed word is fetched once; a function result cannot be sliced in place.
   assign rd_word = reg_rd(a_w + {9'h000, off[7:1]});
   always_comb begin
      tx_byte = buf_q[0];
      if (tx_idx_q == tx_len_q - 8'h02) begin
         tx_byte = crc_tx_q[7:0];
      end else if (tx_idx_q == tx_len_q - 8'h01) begin
         tx_byte = crc_tx_q[15:8];
      end else if (exc_q != 8'h00) begin
         if (tx_idx_q == 8'h01) tx_byte = buf_q[1] | EXC_FLAG;
         else if (tx_idx_q == 8'h02) tx_byte = exc_q;
      end else if (write_q) begin
         tx_byte = buf_q[tx_idx_q[2:0]];
      end else if (tx_idx_q == 8'h01) begin
         tx_byte = buf_q[1];
      end else if (tx_idx_q == 8'h02) begin
         tx_byte = {buf_q[5][6:0], 1'b0};
      end else if (tx_idx_q > 8'h02) begin
         tx_byte = off[0] ? rd_word[7:0] : rd_word[15:8];
      end
   end

   fms_crc_step u_crc_tx (
      .crc_i(crc_tx_q),
      .data_i(tx_byte),
      .crc_o(crc_tx_n)
   );

   // Transmit sequencer; it starts only from an accepted request.
   // The driver stays enabled for the whole reply so bytes go out back to back.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         link_q <= LK_LISTEN;
         de_q <= 1'b0;
         tx_q <= 1'b1;
         tx_busy_q <= 1'b0;
         tx_cnt_q <= 14'h0000;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 10'h3ff;
         tx_idx_q <= 8'h00;
         tx_len_q <= 8'h00;
         crc_tx_q <= CRC_INIT;
         exc_q <= 8'h00;
         write_q <= 1'b0;
      end else begin
         unique case (link_q)
            LK_LISTEN: begin
               if (accept) begin
                  link_q <= LK_SEND;
                  de_q <= 1'b1;
                  exc_q <= exc_d;
                  write_q <= (buf_q[1] == FC_WRITE);
                  tx_idx_q <= 8'h00;
                  crc_tx_q <= CRC_INIT;
                  tx_len_q <= (exc_d != 8'h00) ? LEN_EXC : (buf_q[1] == FC_WRITE) ? LEN_WRITE
                              : LEN_READ_BASE + {buf_q[5][6:0], 1'b0};
               end
            end
            LK_SEND: begin
               if (!tx_busy_q) begin
                  if (tx_idx_q == tx_len_q) begin
                     link_q <= LK_LISTEN;
                     de_q <= 1'b0;
                  end else begin
                     tx_busy_q <= 1'b1;
                     tx_q <= 1'b0;
                     tx_sh_q <= {1'b1, tx_byte, 1'b0};
                     tx_bit_q <= 4'h0;
                     tx_cnt_q <= bit_cyc;
                  end
               end else if (tx_cnt_q != 14'h0000) begin
                  tx_cnt_q <= tx_cnt_q - 14'h0001;
               end else if (tx_bit_q == STOP_BIT) begin
                  tx_busy_q <= 1'b0;
                  tx_idx_q <= tx_idx_q + 8'h01;
                  if (tx_idx_q < tx_len_q - 8'h02) begin
                     crc_tx_q <= crc_tx_n;
                  end
               end else begin
                  tx_cnt_q <= bit_cyc;
                  tx_bit_q <= tx_bit_q + 4'h1;
                  tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                  tx_q <= tx_sh_q[1];
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_frame_done;
      frame_end ##0 (gap_bits_q == SILENCE_BITS - 6'h01);
   endsequence
   a_reply_cause: assert property ($rose(de_q) |-> $past(accept))
      else $error("driver enabled without accepted request");
   a_drive_state: assert property (de_q |-> link_q == LK_SEND)
      else $error("driver enabled outside reply");
   a_start_low: assert property ($rose(de_q) |=> !tx_q ##1 !tx_q)
      else $error("reply does not open with start bit");
   a_stop_high: assert property (tx_busy_q && tx_bit_q == STOP_BIT |-> tx_q)
      else $error("stop bit not high");
   a_addr_match: assert property ($rose(de_q) |-> $past(buf_q[0]) == $past(station_q))
      else $error("reply to foreign station");
   a_crc_intact: assert property ($rose(de_q) |-> $past(crc_rx_q) == 16'h0000
                                  && $past(nbytes_q) == REQ_LEN)
      else $error("reply to damaged frame");
   a_rate_legal: assert property (rate_q == RATE_480 || rate_q == RATE_960
                                  || rate_q == RATE_1920 || rate_q == RATE_11520)
      else $error("illegal line rate stored");
   a_cfg_cause: assert property ($changed(rate_q) || $changed(station_q) |->
                                 $past(accept) && $past(buf_q[1]) == FC_WRITE)
      else $error("configuration changed without write");
   a_byte_count: assert property ($rose(de_q) && !write_q && exc_q == 8'h00 |->
                                  tx_len_q == LEN_READ_BASE + 8'(v_w << 1))
      else $error("read reply length wrong");
   a_gap_end: assert property (accept |-> s_frame_done)
      else $error("frame decoded before silence");
endmodule : fms_modbus_slave

// ==== testbench/flow_meter_modbus_slave_tb.sv ====
// Self-checking bench for the flow meter serial slave.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module flow_meter_modbus_slave_tb;
   import fms_pkg::*;
   localparam int C480 = 16;
   localparam int C960 = 12;
   localparam int C1920 = 10;
   localparam int C11520 = 8;
   logic mclk, nrst, rx, tx, de;
   logic [15:0] flow, temp, rate;
   logic [7:0] station;
   int err_count, compares, bc;
   logic [15:0] rates [4] = '{RATE_1920, RATE_11520, RATE_480, RATE_960};
   int cycs [4] = '{C1920, C11520, C480, C960};

   // Short bit periods keep the run small; all expectations use the same figures.
   fms_modbus_slave #(.BIT_CYC_R480(C480), .BIT_CYC_R960(C960), .BIT_CYC_R1920(C1920),
      .BIT_CYC_R11520(C11520)) u_dut (.mclk_i(mclk), .nrst_i(nrst), .rx_i(rx),
      .flow_i(flow), .temp_i(temp), .tx_o(tx), .de_o(de), .station_o(station),
      .line_rate_o(rate));
   fms_master_model u_master (.mclk_i(mclk), .line_i(tx), .line_o(rx));

   // Free-running 50 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   // Sends one request; an empty expectation means the slave must stay silent.
   task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$], input int rbc,
      input logic bad);
      logic [7:0] b;
      logic ok;
      logic [15:0] c;
      int n;
      u_master.send_frame(req, bc, bad);
      if (exp.size() == 0) begin
         repeat (45 * bc) begin
            @(posedge mclk);
            `CHK("quiet de", 1'b0, de)
         end
         return;
      end
      c = u_master.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
      n = 0;
      while (de !== 1'b1 && n < 37 * bc) begin
         @(posedge mclk);
         n++;
      end
      `CHK("silence", 1'b1, (n >= 33 * bc && n < 37 * bc))
      if (n >= 37 * bc) tally_and_finish();
      foreach (exp[i]) begin
         u_master.recv_byte(rbc, b, ok);
         `CHK("framing", 1'b1, ok)
         if (!ok) tally_and_finish();
         `CHK("reply byte", exp[i], b)
      end
      n = 0;
      while (de !== 1'b0 && n < 3 * rbc) begin
         @(posedge mclk);
         n++;
      end
      `CHK("de release", 1'b0, de)
      bc = rbc;
      // The master leaves a full silence before the next request.
      repeat (40 * bc) @(posedge mclk);
   endtask : xact

   // Main sequence: reset values, reads, refusals, writes and every line rate.
   initial begin
      err_count = 0;
      compares = 0;
      bc = C960;
      nrst = 1'b0;
      flow = 16'h0064;
      temp = 16'h0123;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      `CHK("crc example", 16'h0a84, u_master.crc16('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}))
      `CHK("station", 8'h01, station)
      `CHK("rate", RATE_960, rate)
      `CHK("tx idle", 1'b1, tx)
      `CHK("de idle", 1'b0, de)
      xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h64}, bc, 0);
      xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02},
         '{8'h01, 8'h03, 8'h04, 8'h00, 8'h64, 8'h01, 8'h23}, bc, 0);
      xact('{8'h01, 8'h03, 8'h00, 8'h28, 8'h00, 8'h02},
         '{8'h01, 8'h03, 8'h04, 8'h00, 8'h01, 8'h03, 8'hc0}, bc, 0);
      xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, bc, 1);
      xact('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, bc, 0);
      xact('{8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h05}, '{8'h01, 8'h86, 8'h02}, bc, 0);
      xact('{8'h01, 8'h06, 8'h00, 8'h28, 8'h00, 8'h05},
         '{8'h01, 8'h06, 8'h00, 8'h28, 8'h00, 8'h05}, bc, 0);
      `CHK("station new", 8'h05, station)
      xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{}, bc, 0);
      flow <= 16'h062a;
      xact('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h05, 8'h03, 8'h02, 8'h06, 8'h2a}, bc, 0);
      for (int i = 0; i < 4; i++) begin
         xact('{8'h05, 8'h06, 8'h00, 8'h29, rates[i][15:8], rates[i][7:0]},
            '{8'h05, 8'h06, 8'h00, 8'h29, rates[i][15:8], rates[i][7:0]}, cycs[i], 0);
         `CHK("rate new", rates[i], rate)
      end
      xact('{8'h05, 8'h06, 8'h00, 8'h29, 8'h03, 8'he8}, '{8'h05, 8'h86, 8'h03}, bc, 0);
      `CHK("rate kept", RATE_960, rate)
      tally_and_finish();
   end
endmodule : flow_meter_modbus_slave_tb

// ==== testbench/fms_master_model.sv ====
// Behavioural bus master that frames requests and reads back replies.
`timescale 1ns/10ps
module fms_master_model (
   input wire logic mclk_i,
   input wire logic line_i,
   output logic line_o
);
   // The master's driver holds the line idle high between characters and frames.
   initial begin
      line_o = 1'b1;
   end

   // Reflected frame check; used by the master and by the bench for expected replies.
   function automatic logic [15:0] crc16(input logic [7:0] d[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (d[i]) begin
         c ^= {8'h00, d[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction : crc16

   // Start low, eight data bits LSB first, one stop high, no parity.
   task automatic send_byte(input logic [7:0] b, input int bc);
      logic [9:0] sh;
      sh = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk_i);
         line_o <= sh[i];
         repeat (bc - 1) @(posedge mclk_i);
      end
   endtask : send_byte

   // Only the master opens a transaction; bad flips the low check bit so the slave stays silent.
   task automatic send_frame(input logic [7:0] d[$], input int bc, input logic bad);
      logic [15:0] c;
      c = crc16(d) ^ {15'h0000, bad};
      foreach (d[i]) send_byte(d[i], bc);
      send_byte(c[7:0], bc);
      send_byte(c[15:8], bc);
   endtask : send_frame

   // Mid-bit sampling; ok drops on a missing start bit or a low stop bit.
   task automatic recv_byte(input int bc, output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (line_i !== 1'b0 && n < 40 * bc) begin
         @(posedge mclk_i);
         n++;
      end
      ok = (n < 40 * bc);
      repeat (bc / 2) @(posedge mclk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (bc) @(posedge mclk_i);
         b[i] = line_i;
      end
      repeat (bc) @(posedge mclk_i);
      ok = ok && (line_i === 1'b1);
   endtask : recv_byte
endmodule : fms_master_model
